// ---- include/cpc_pkg.sv ----
// package of register map, field layout and reset values for clip control
package cpc_pkg;
    localparam logic [7:0] CPC_ADDR_PROT      = 8'h21;
    localparam logic [7:0] CPC_ADDR_CLIPCTL   = 8'h22;
    localparam logic [7:0] CPC_ADDR_THRESH    = 8'h23;
    localparam logic [7:0] CPC_ADDR_CLIPFLG   = 8'h24;
    localparam logic [7:0] CPC_ADDR_OCFLG     = 8'h25;
    localparam logic [7:0] CPC_ADDR_PHASEHP   = 8'h26;
    localparam logic [7:0] CPC_ADDR_SPREAD    = 8'h28;

    localparam logic [7:0] CPC_RST_PROT       = 8'h00;
    localparam logic [7:0] CPC_RST_CLIPCTL    = 8'h01;
    localparam logic [7:0] CPC_RST_THRESH     = 8'h14;
    localparam logic [7:0] CPC_RST_PHASEHP    = 8'h40;
    localparam logic [7:0] CPC_RST_SPREAD     = 8'h0A;

    // writable masks; other bits hold reset value
    localparam logic [7:0] CPC_WMASK_PROT     = 8'hE8;
    localparam logic [7:0] CPC_WMASK_CLIPCTL  = 8'h07;
    localparam logic [7:0] CPC_WMASK_PHASEHP  = 8'h0F;
    localparam logic [7:0] CPC_WMASK_SPREAD   = 8'hE0;

    localparam int CPC_BIT_CLEAR     = 7;
    localparam int CPC_BIT_SWAP      = 6;
    localparam int CPC_BIT_SUPPRESS  = 5;
    localparam int CPC_BIT_AUTOREST  = 3;
    localparam int CPC_BIT_ROUTE     = 2;
    localparam int CPC_BIT_NOLATCH   = 1;
    localparam int CPC_BIT_DET_EN    = 0;
    localparam int CPC_BIT_INV       = 3;
    localparam int CPC_BIT_SS_BW     = 7;
    localparam int CPC_BIT_SS_HALF   = 6;
    localparam int CPC_BIT_PHASE     = 5;
    localparam int CPC_HP_LSB        = 0;
    localparam int CPC_HP_W          = 3;
    localparam int CPC_NUM_CH        = 4;
endpackage

// ---- verification/cpc_host_model.sv ----
// host model driving single-byte register transfers
`timescale 1ns/100ps
module cpc_host_model
(
    input  wire logic       i_ref_clk,
    output logic            o_wr_en,
    output logic            o_rd_en,
    output logic [7:0]      o_addr,
    output logic [7:0]      o_wdata
);
    initial
    begin
        o_wr_en = 1'b0;
        o_rd_en = 1'b0;
        o_addr  = 8'h00;
        o_wdata = 8'h00;
    end
    // one strobe cycle; address and data scrambled once released
    task automatic xfer(input logic wr, input logic [7:0] a, d);
        @(posedge i_ref_clk);
        #1;
        o_wr_en = wr;
        o_rd_en = !wr;
        o_addr  = a;
        o_wdata = d;
        @(posedge i_ref_clk);
        #1;
        o_wr_en = 1'b0;
        o_rd_en = 1'b0;
        o_addr  = ~a;
        o_wdata = ~d;
    endtask
endmodule

// ---- verification/cpc_regs_assertions.sv ----
// checker of register port timing and configuration outputs
`timescale 1ns/100ps
module cpc_chk
    import cpc_pkg::*;
#(
    parameter int NUM_CH = CPC_NUM_CH
)
(
    input wire logic              i_ref_clk,
    input wire logic              i_rst_n,
    input wire logic              i_wr_en,
    input wire logic              i_rd_en,
    input wire logic [7:0]        i_addr,
    input wire logic [7:0]        i_wdata,
    input wire logic [NUM_CH-1:0] i_current_limit,
    input wire logic [7:0]        o_rdata,
    input wire logic              o_rd_valid,
    input wire logic              o_fault_clear,
    input wire logic              o_parallel_source_swap,
    input wire logic              o_bit_clock_phase_invert,
    input wire logic              o_thermal_shutdown_autorestart,
    input wire logic [CPC_HP_W-1:0] o_highpass_cutoff_select,
    input wire logic              o_spread_bandwidth_select,
    input wire logic              o_spread_post_halving,
    input wire logic              o_output_phase_option
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    wire w21 = i_wr_en && i_addr == CPC_ADDR_PROT;
    wire w26 = i_wr_en && i_addr == CPC_ADDR_PHASEHP;
    wire w28 = i_wr_en && i_addr == CPC_ADDR_SPREAD;
    wire clr = w21 && i_wdata[7];
    property p_rv; i_rd_en |=> o_rd_valid; endproperty
    a_rv: assert property (p_rv)
        else $error("read valid missing");
    property p_nv; !i_rd_en |=> !o_rd_valid; endproperty
    a_nv: assert property (p_nv)
        else $error("read valid without read");
    property p_clr; clr |=> o_fault_clear; endproperty
    a_clr: assert property (p_clr)
        else $error("fault clear pulse missing");
    property p_ncl; !clr |=> !o_fault_clear; endproperty
    a_ncl: assert property (p_ncl)
        else $error("fault clear without write");
    property p_sw; w21 |=> o_parallel_source_swap == $past(i_wdata[6]);
    endproperty
    a_sw: assert property (p_sw)
        else $error("source swap wrong");
    property p_ar;
        w21 |=> o_thermal_shutdown_autorestart == $past(i_wdata[3]);
    endproperty
    a_ar: assert property (p_ar)
        else $error("autorestart wrong");
    property p_hp; w26 |=> o_highpass_cutoff_select == $past(i_wdata[2:0]);
    endproperty
    a_hp: assert property (p_hp)
        else $error("highpass select wrong");
    property p_inv;
        w26 |=> o_bit_clock_phase_invert == $past(i_wdata[3]);
    endproperty
    a_inv: assert property (p_inv)
        else $error("phase invert wrong");
    property p_ss; w28 |=> {o_spread_bandwidth_select, o_spread_post_halving,
        o_output_phase_option} == $past(i_wdata[7:5]); endproperty
    a_ss: assert property (p_ss)
        else $error("spread bits wrong");
    property p_oc; i_rd_en && i_addr == CPC_ADDR_OCFLG |=>
        o_rdata[NUM_CH-1:0] == $past(i_current_limit, 2); endproperty
    a_oc: assert property (p_oc)
        else $error("overcurrent flags wrong");
endmodule
bind cpc_regs cpc_chk #(.NUM_CH(NUM_CH)) u_chk (
    .i_ref_clk                      (i_ref_clk),
    .i_rst_n                        (i_rst_n),
    .i_wr_en                        (i_wr_en),
    .i_rd_en                        (i_rd_en),
    .i_addr                         (i_addr),
    .i_wdata                        (i_wdata),
    .i_current_limit                (i_current_limit),
    .o_rdata                        (o_rdata),
    .o_rd_valid                     (o_rd_valid),
    .o_fault_clear                  (o_fault_clear),
    .o_parallel_source_swap         (o_parallel_source_swap),
    .o_bit_clock_phase_invert       (o_bit_clock_phase_invert),
    .o_thermal_shutdown_autorestart (o_thermal_shutdown_autorestart),
    .o_highpass_cutoff_select       (o_highpass_cutoff_select),
    .o_spread_bandwidth_select      (o_spread_bandwidth_select),
    .o_spread_post_halving          (o_spread_post_halving),
    .o_output_phase_option          (o_output_phase_option)
);

// ---- verification/tb_top.sv ----
// self-checking bench for the clip and protection register bank
`timescale 1ns/100ps
module tb_top;
    import cpc_pkg::*;
    logic        clk, rst_n, wr_en, rd_en, cyc_end, rv, warn, fault;
    logic        ot, tsd;
    logic [7:0]  addr, wdata, rdata, v;
    logic [3:0]  full, lim;
    logic [31:0] seed = 32'h1657;
    logic [7:0]  exp_q[$];
    int          err_total, n_tests;
    logic [7:0]  ra[8] = '{8'h21, 8'h22, 8'h23, 8'h24,
                           8'h25, 8'h26, 8'h28, 8'h27};
    logic [7:0]  rr[8] = '{8'h00, 8'h01, 8'h14, 8'h00,
                           8'h00, 8'h40, 8'h0A, 8'h00};
    logic [7:0]  rm[8] = '{8'hE8, 8'h07, 8'hFF, 8'h00,
                           8'h00, 8'h0F, 8'hE0, 8'h00};
    cpc_host_model u_host (.i_ref_clk(clk), .o_wr_en(wr_en), .o_rd_en(rd_en),
        .o_addr(addr), .o_wdata(wdata));
    cpc_regs dut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_wr_en(wr_en),
        .i_rd_en(rd_en), .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata),
        .o_rd_valid(rv), .i_pwm_cycle_end(cyc_end), .i_full_duty(full),
        .i_current_limit(lim), .i_thermal_shutdown(ot), .o_warn_pin(warn),
        .o_fault_pin(fault), .o_thermal_shutdown(tsd), .o_fault_clear(),
        .o_parallel_source_swap(), .o_thermal_shutdown_autorestart(),
        .o_bit_clock_phase_invert(), .o_highpass_cutoff_select(),
        .o_spread_bandwidth_select(), .o_spread_post_halving(),
        .o_output_phase_option());
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic end_sim;
        if (err_total == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, g);
        n_tests++;
        if (g !== e)
        begin
            err_total++;
            $display("unexpected %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, d);
        u_host.xfer(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, e);
        exp_q.push_back(e);
        u_host.xfer(1'b0, a, 8'h00);
    endtask
    task automatic pins(input logic w, f);
        chk("warn", {7'h0, w}, {7'h0, warn});
        chk("fault", {7'h0, f}, {7'h0, fault});
    endtask
    // n pwm cycles, mask m full duty, then let flags settle
    task automatic clip(input logic [3:0] m, input int n);
        repeat (n)
        begin
            wt(1);
            cyc_end = 1'b1;
            full = m;
            wt(1);
            cyc_end = 1'b0;
            full = ~m;
        end
        wt(3);
    endtask
    always @(negedge clk)
        if (rv === 1'b1)
            chk("rdata", exp_q.pop_front(), rdata);
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial
    begin
        #200_000;
        err_total++;
        end_sim();
    end
    initial
    begin
        rst_n = 1'b0;
        cyc_end = 1'b0;
        full = 4'h0;
        lim = 4'h0;
        ot = 1'b0;
        wt(4);
        rst_n = 1'b1;
        foreach (ra[i]) rd(ra[i], rr[i]);
        for (int k = 0; k < 3; k++)
            foreach (ra[i])
            begin
                v = (k == 0) ? 8'hFF : seed[7:0];
                seed = lfsr_next(seed);
                wr(ra[i], v);
                rd(ra[i], (rr[i] & ~rm[i]) | (v & rm[i]));
            end
        for (int c = 0; c < 8; c++)
        begin
            wr(CPC_ADDR_PHASEHP, 8'(c));
            rd(CPC_ADDR_PHASEHP, 8'h40 | 8'(c));
        end
        wr(CPC_ADDR_PROT, 8'h00);
        wr(CPC_ADDR_CLIPCTL, 8'h01);
        wr(CPC_ADDR_THRESH, 8'h03);
        lim = seed[3:0];
        wt(3);
        rd(CPC_ADDR_OCFLG, {4'h0, lim});
        clip(4'h1, 2);
        pins(1'b0, 1'b0);
        clip(4'h1, 1);
        pins(1'b1, 1'b0);
        rd(CPC_ADDR_CLIPFLG, 8'h01);
        clip(4'h0, 1);
        pins(1'b1, 1'b0);
        wr(CPC_ADDR_PROT, 8'h80);
        wt(2);
        pins(1'b0, 1'b0);
        rd(CPC_ADDR_CLIPFLG, 8'h00);
        wr(CPC_ADDR_CLIPCTL, 8'h05);
        clip(4'h4, 3);
        pins(1'b0, 1'b1);
        wr(CPC_ADDR_PROT, 8'h80);
        wr(CPC_ADDR_CLIPCTL, 8'h03);
        clip(4'h2, 3);
        pins(1'b1, 1'b0);
        clip(4'h0, 1);
        pins(1'b0, 1'b0);
        wr(CPC_ADDR_PROT, 8'h20);
        clip(4'h1, 3);
        pins(1'b0, 1'b0);
        clip(4'h0, 1);
        wr(CPC_ADDR_PROT, 8'h00);
        wr(CPC_ADDR_CLIPCTL, 8'h00);
        clip(4'hF, 3);
        pins(1'b0, 1'b0);
        rd(CPC_ADDR_CLIPFLG, 8'h00);
        ot = 1'b1;
        wt(2);
        ot = 1'b0;
        wt(3);
        pins(1'b0, 1'b1);
        chk("tsd", 8'h01, {7'h0, tsd});
        wr(CPC_ADDR_PROT, 8'h80);
        wt(2);
        pins(1'b0, 1'b0);
        chk("tsd", 8'h00, {7'h0, tsd});
        wr(CPC_ADDR_PROT, 8'h08);
        ot = 1'b1;
        wt(3);
        pins(1'b0, 1'b1);
        ot = 1'b0;
        wt(3);
        pins(1'b0, 1'b0);
        wr(CPC_ADDR_SPREAD, 8'hE0);
        rd(CPC_ADDR_SPREAD, 8'hEA);
        wt(3);
        end_sim();
    end
endmodule

// ---- verilog/cpc_regs.sv ----
// clip and protection control register bank
`timescale 1ns/100ps
// Notes on behaviour
// - writing clear bit clears latched faults
// - bit six swaps parallel bridge source
// - bit three selects thermal shutdown autorestart
// - route bit splits clip between pins
// - hold select: latched or live pin
// - detect enable resets to one
// - report after threshold full-duty cycles
// - clip flags readable at 0x24
// - overcurrent flags readable at 0x25
// - three-bit highpass corner, reset zero
// - spread register resets to 0x0A
// - suppress bit blocks clip on pin
module cpc_regs
    import cpc_pkg::*;
#(
    parameter int NUM_CH = CPC_NUM_CH
)
(
    // clock and reset
    input  wire logic              i_ref_clk,
    input  wire logic              i_rst_n,
    // register port from serial control
    input  wire logic              i_wr_en,
    input  wire logic              i_rd_en,
    input  wire logic [7:0]        i_addr,
    input  wire logic [7:0]        i_wdata,
    output logic      [7:0]        o_rdata,
    output logic                   o_rd_valid,
    // amplifier status
    input  wire logic              i_pwm_cycle_end,
    input  wire logic [NUM_CH-1:0] i_full_duty,
    input  wire logic [NUM_CH-1:0] i_current_limit,
    input  wire logic              i_thermal_shutdown,
    // fault and warning pins
    output logic                   o_warn_pin,
    output logic                   o_fault_pin,
    output logic                   o_thermal_shutdown,
    output logic                   o_fault_clear,
    // configuration to datapath
    output logic                   o_parallel_source_swap,
    output logic                   o_thermal_shutdown_autorestart,
    output logic                   o_bit_clock_phase_invert,
    output logic [CPC_HP_W-1:0]    o_highpass_cutoff_select,
    output logic                   o_spread_bandwidth_select,
    output logic                   o_spread_post_halving,
    output logic                   o_output_phase_option
);
    typedef struct packed {
        logic [7:0]        prot;
        logic [7:0]        clipctl;
        logic [7:0]        thresh;
        logic [7:0]        phasehp;
        logic [7:0]        spread;
        logic [NUM_CH-1:0] clip_flag;
        logic [NUM_CH-1:0] oc_flag;
        logic              thermal_shutdown;
        logic              clear;
        logic              warn;
        logic              fault;
        logic [7:0]        rdata;
        logic              rd_valid;
    } cpc_state_t;

    cpc_state_t        st_q;
    cpc_state_t        st_d;
    logic [NUM_CH-1:0] det;
    logic              clr_wr;
    logic              latch_mode;
    logic [NUM_CH-1:0] clip_src;

    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch++)
        begin : g_ch
            cpc_sat_counter u_cnt (
                .i_ref_clk   (i_ref_clk),
                .i_rst_n     (i_rst_n),
                .i_enable    (st_q.clipctl[CPC_BIT_DET_EN]),
                .i_cycle_end (i_pwm_cycle_end),
                .i_full_duty (i_full_duty[ch]),
                .i_threshold (st_q.thresh),
                .o_detect    (det[ch])
            );
        end
    endgenerate

    assign clr_wr = i_wr_en && (i_addr == CPC_ADDR_PROT)
                    && i_wdata[CPC_BIT_CLEAR];
    assign latch_mode = !st_q.clipctl[CPC_BIT_NOLATCH];

    always_comb
    begin
        st_d          = st_q;
        st_d.rd_valid = 1'b0;
        st_d.clear    = clr_wr;

        // writes, reserved bits keep reset value
        if (i_wr_en)
        begin
            case (i_addr)
                CPC_ADDR_PROT:
                    st_d.prot = (i_wdata & CPC_WMASK_PROT)
                                | (CPC_RST_PROT & ~CPC_WMASK_PROT);
                CPC_ADDR_CLIPCTL:
                    st_d.clipctl = (i_wdata & CPC_WMASK_CLIPCTL)
                                   | (CPC_RST_CLIPCTL & ~CPC_WMASK_CLIPCTL);
                CPC_ADDR_THRESH:
                    st_d.thresh = i_wdata;
                CPC_ADDR_PHASEHP:
                    st_d.phasehp = (i_wdata & CPC_WMASK_PHASEHP)
                                   | (CPC_RST_PHASEHP & ~CPC_WMASK_PHASEHP);
                CPC_ADDR_SPREAD:
                    st_d.spread = (i_wdata & CPC_WMASK_SPREAD)
                                  | (CPC_RST_SPREAD & ~CPC_WMASK_SPREAD);
                default:
                    st_d.prot = st_q.prot;
            endcase
        end

        // clip flags: latched until clear, else live; set beats clear
        if (latch_mode)
        begin
            st_d.clip_flag = (clr_wr ? '0 : st_q.clip_flag) | det;
        end
        else
        begin
            st_d.clip_flag = det;
        end
        st_d.oc_flag = i_current_limit;

        // thermal shutdown latch or autorestart
        if (st_q.prot[CPC_BIT_AUTOREST])
        begin
            st_d.thermal_shutdown = i_thermal_shutdown;
        end
        else
        begin
            st_d.thermal_shutdown = (clr_wr ? 1'b0 : st_q.thermal_shutdown) | i_thermal_shutdown;
        end

        // pin routing with suppress
        if (st_q.prot[CPC_BIT_SUPPRESS])
        begin
            st_d.warn  = 1'b0;
            st_d.fault = st_d.thermal_shutdown;
        end
        else if (st_q.clipctl[CPC_BIT_ROUTE])
        begin
            st_d.warn  = |st_d.clip_flag[1:0];
            st_d.fault = (|st_d.clip_flag[NUM_CH-1:2]) | st_d.thermal_shutdown;
        end
        else
        begin
            st_d.warn  = |st_d.clip_flag;
            st_d.fault = st_d.thermal_shutdown;
        end

        // read mux
        if (i_rd_en)
        begin
            st_d.rd_valid = 1'b1;
            case (i_addr)
                CPC_ADDR_PROT:    st_d.rdata = st_q.prot;
                CPC_ADDR_CLIPCTL: st_d.rdata = st_q.clipctl;
                CPC_ADDR_THRESH:  st_d.rdata = st_q.thresh;
                CPC_ADDR_CLIPFLG:
                    st_d.rdata = {{(8-NUM_CH){1'b0}}, st_q.clip_flag};
                CPC_ADDR_OCFLG:
                    st_d.rdata = {{(8-NUM_CH){1'b0}}, st_q.oc_flag};
                CPC_ADDR_PHASEHP: st_d.rdata = st_q.phasehp;
                CPC_ADDR_SPREAD:  st_d.rdata = st_q.spread;
                default:          st_d.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            st_q           <= '0;
            st_q.prot      <= CPC_RST_PROT;
            st_q.clipctl   <= CPC_RST_CLIPCTL;
            st_q.thresh    <= CPC_RST_THRESH;
            st_q.phasehp   <= CPC_RST_PHASEHP;
            st_q.spread    <= CPC_RST_SPREAD;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // outputs straight from flops
    assign o_rdata            = st_q.rdata;
    assign o_rd_valid         = st_q.rd_valid;
    assign o_warn_pin         = st_q.warn;
    assign o_fault_pin        = st_q.fault;
    assign o_thermal_shutdown = st_q.thermal_shutdown;
    assign o_fault_clear      = st_q.clear;
    assign o_parallel_source_swap = st_q.prot[CPC_BIT_SWAP];
    assign o_thermal_shutdown_autorestart = st_q.prot[CPC_BIT_AUTOREST];
    assign o_bit_clock_phase_invert = st_q.phasehp[CPC_BIT_INV];
    assign o_highpass_cutoff_select =
        st_q.phasehp[CPC_HP_LSB +: CPC_HP_W];
    assign o_spread_bandwidth_select = st_q.spread[CPC_BIT_SS_BW];
    assign o_spread_post_halving     = st_q.spread[CPC_BIT_SS_HALF];
    assign o_output_phase_option     = st_q.spread[CPC_BIT_PHASE];
endmodule

// ---- verilog/cpc_sat_counter.sv ----
// per-channel run counter of full-duty pwm cycles
`timescale 1ns/100ps
module cpc_sat_counter
    import cpc_pkg::*;
(
    // clock and reset
    input  wire logic       i_ref_clk,
    input  wire logic       i_rst_n,
    // pwm cycle inputs
    input  wire logic       i_enable,
    input  wire logic       i_cycle_end,
    input  wire logic       i_full_duty,
    input  wire logic [7:0] i_threshold,
    // detection
    output logic            o_detect
);
    typedef struct packed {
        logic [7:0] count;
        logic       detect;
    } cpc_cnt_t;

    cpc_cnt_t st_q;
    cpc_cnt_t st_d;

    always_comb
    begin
        st_d = st_q;
        if (!i_enable)
        begin
            st_d.count  = 8'h00;
            st_d.detect = 1'b0;
        end
        else if (i_cycle_end)
        begin
            if (!i_full_duty)
            begin
                st_d.count  = 8'h00;
                st_d.detect = 1'b0;
            end
            else
            begin
                if (st_q.count != 8'hFF)
                begin
                    st_d.count = st_q.count + 8'h01;
                end
                // at least threshold cycles in a row
                st_d.detect = ((st_q.count + 8'h01) >= i_threshold)
                              || (st_q.count == 8'hFF);
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign o_detect = st_q.detect;
endmodule
